//--- design/sfb_pkg.sv
package sfb_pkg;

   // Status register bit positions
   localparam int STAT_WDT_BIT   = 4;
   localparam int STAT_SLEEP_BIT = 3;
   localparam int STAT_ZERO_BIT  = 2;
   localparam int STAT_NIB_BIT   = 1;
   localparam int STAT_CARRY_BIT = 0;
   localparam logic [7:0] STAT_IMPL_MASK = 8'h1f;

   // Reset values
   localparam logic FLAG_RST_POR   = 1'b1;
   localparam logic RESULT_RST_POR = 1'b0;

   // Address layout
   localparam int ADDR_W     = 12;
   localparam int BANK_W     = 5;
   localparam int OFS_W      = 7;
   localparam int NUM_BANKS  = 32;

   // Bank partition offsets
   localparam logic [6:0] OFS_STATUS     = 7'h03;
   localparam logic [6:0] OFS_CORE_LAST  = 7'h0b;
   localparam logic [6:0] OFS_PERIPH_LO  = 7'h0c;
   localparam logic [6:0] OFS_PERIPH_HI  = 7'h1f;
   localparam logic [6:0] OFS_GPR_LO     = 7'h20;
   localparam logic [6:0] OFS_GPR_HI     = 7'h6f;
   localparam logic [6:0] OFS_COMMON_LO  = 7'h70;
   localparam int GPR_PER_BANK = 80;
   localparam int COMMON_BYTES = 16;

   // Linear window base for indirect access
   localparam logic [15:0] LIN_BASE = 16'h2000;

   // ALU operations
   typedef enum logic [2:0] {
      SFB_OP_NONE,
      SFB_OP_ADD,
      SFB_OP_SUB,
      SFB_OP_LOGIC
   } sfb_op_t;

   // Data memory region classes
   typedef enum logic [2:0] {
      SFB_RG_CORE,
      SFB_RG_PERIPH,
      SFB_RG_GPR,
      SFB_RG_COMMON,
      SFB_RG_NONE
   } sfb_region_t;

endpackage

//--- design/sfb_status_banks.sv
`timescale 1ns/1ns
module sfb_status_banks #(
   parameter int GPR_BANKS = 8
) (
   // Clock and reset
   input  wire logic                     clock,
   input  wire logic                     nrst,
   input  wire logic                     powerReset,
   // Execution events
   input  wire logic                     watchdogClearInstr,
   input  wire logic                     sleepInstr,
   input  wire logic                     watchdogTimeout,
   // Arithmetic request
   input  wire logic                     aluValid,
   input  wire sfb_pkg::sfb_op_t         aluOp,
   input  wire logic [7:0]               aluA,
   input  wire logic [7:0]               aluB,
   input  wire logic [sfb_pkg::ADDR_W-1:0] aluDest,
   input  wire logic                     aluToFile,
   // Data memory access
   input  wire logic                     memWrite,
   input  wire logic                     memRead,
   input  wire logic [sfb_pkg::ADDR_W-1:0] memAddr,
   input  wire logic [7:0]               memWdata,
   // Linear indirect access
   input  wire logic                     linRead,
   input  wire logic                     linWrite,
   input  wire logic [15:0]              linAddr,
   // Results
   output logic [7:0]                    aluResult,
   output logic [7:0]                    statusOut,
   output logic [7:0]                    memRdata,
   output logic                          memRvalid,
   output logic [2:0]                    memRegion,
   output logic                          periphSel
);

   localparam int GPR_TOTAL = GPR_BANKS * sfb_pkg::GPR_PER_BANK;
   localparam int GPR_IW    = $clog2(GPR_TOTAL);

   if (GPR_BANKS < 1 || GPR_BANKS > sfb_pkg::NUM_BANKS)
   begin : g_bank_check
      $error("GPR_BANKS out of range");
   end

   typedef struct packed {
      logic        wdtFlag;
      logic        sleepFlag;
      logic        zeroFlag;
      logic        nibFlag;
      logic        carryFlag;
      logic [7:0]  aluResult;
      logic [7:0]  rdata;
      logic        rvalid;
      logic [2:0]  region;
      logic        periph;
   } sfb_state_t;

   sfb_state_t st_ff;
   sfb_state_t nxt_st;
   logic [7:0] gprMem_ff    [GPR_TOTAL];
   logic [7:0] commonMem_ff [sfb_pkg::COMMON_BYTES];

   function automatic sfb_pkg::sfb_region_t classify(input logic [6:0] ofs);
      if (ofs <= sfb_pkg::OFS_CORE_LAST)
         return sfb_pkg::SFB_RG_CORE;
      else if (ofs <= sfb_pkg::OFS_PERIPH_HI)
         return sfb_pkg::SFB_RG_PERIPH;
      else if (ofs <= sfb_pkg::OFS_GPR_HI)
         return sfb_pkg::SFB_RG_GPR;
      else
         return sfb_pkg::SFB_RG_COMMON;
   endfunction

   // Flat index of a banked RAM byte; valid only for implemented banks
   function automatic logic [GPR_IW-1:0] gprIndex(input logic [4:0] bank,
                                                  input logic [6:0] ofs);
      logic [15:0] idx;
      idx = 16'(bank) * 16'(sfb_pkg::GPR_PER_BANK) + 16'(ofs - sfb_pkg::OFS_GPR_LO);
      return idx[GPR_IW-1:0];
   endfunction

   function automatic logic [7:0] statusByte(input sfb_state_t s);
      logic [7:0] b;
      b = 8'h00;
      b[sfb_pkg::STAT_WDT_BIT]   = s.wdtFlag;
      b[sfb_pkg::STAT_SLEEP_BIT] = s.sleepFlag;
      b[sfb_pkg::STAT_ZERO_BIT]  = s.zeroFlag;
      b[sfb_pkg::STAT_NIB_BIT]   = s.nibFlag;
      b[sfb_pkg::STAT_CARRY_BIT] = s.carryFlag;
      return b;
   endfunction

   // Address split
   logic [4:0] memBank;
   logic [6:0] memOfs;
   assign memBank = memAddr[sfb_pkg::ADDR_W-1:sfb_pkg::OFS_W];
   assign memOfs  = memAddr[sfb_pkg::OFS_W-1:0];

   // Linear window decode
   logic [15:0] linOfs;
   logic        linHit;
   assign linOfs = linAddr - sfb_pkg::LIN_BASE;
   assign linHit = (linAddr >= sfb_pkg::LIN_BASE) && (linOfs < 16'(GPR_TOTAL));

   // Adder shared by add and subtract
   logic [8:0] sum;
   logic [4:0] nibSum;
   logic [7:0] opB;
   logic [7:0] logicRes;
   logic       isArith;
   assign opB     = (aluOp == sfb_pkg::SFB_OP_SUB) ? ~aluB : aluB;
   assign isArith = (aluOp == sfb_pkg::SFB_OP_ADD) || (aluOp == sfb_pkg::SFB_OP_SUB);
   assign sum     = {1'b0, aluA} + {1'b0, opB} + {8'h00, aluOp == sfb_pkg::SFB_OP_SUB};
   assign nibSum  = {1'b0, aluA[3:0]} + {1'b0, opB[3:0]}
                    + {4'h0, aluOp == sfb_pkg::SFB_OP_SUB};
   assign logicRes = aluA & aluB;

   logic [7:0] result;
   assign result = isArith ? sum[7:0] : logicRes;

   logic destIsStatus;
   logic memIsStatus;
   assign destIsStatus = aluValid && aluToFile
                         && aluDest[sfb_pkg::OFS_W-1:0] == sfb_pkg::OFS_STATUS;
   assign memIsStatus  = memOfs == sfb_pkg::OFS_STATUS;

   // Writes into RAM
   logic             gprWe;
   logic [GPR_IW-1:0] gprWi;
   logic             comWe;
   logic [3:0]       comWi;
   sfb_pkg::sfb_region_t wrRegion;
   assign wrRegion = classify(memOfs);

   always_comb
   begin
      gprWe = 1'b0;
      gprWi = '0;
      comWe = 1'b0;
      comWi = memOfs[3:0];
      if (linWrite && linHit)
      begin
         gprWe = 1'b1;
         gprWi = linOfs[GPR_IW-1:0];
      end
      // Six bits so that a full set of 32 banks still compares correctly
      else if (memWrite && wrRegion == sfb_pkg::SFB_RG_GPR && {1'b0, memBank} < 6'(GPR_BANKS))
      begin
         gprWe = 1'b1;
         gprWi = gprIndex(memBank, memOfs);
      end
      else if (memWrite && wrRegion == sfb_pkg::SFB_RG_COMMON)
         comWe = 1'b1;
   end

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.rvalid = 1'b0;
      // Software write to status: only the result flags take data
      if (memWrite && memIsStatus && !(aluValid && isArith) && !(aluValid
          && aluOp == sfb_pkg::SFB_OP_LOGIC))
      begin
         nxt_st.zeroFlag  = memWdata[sfb_pkg::STAT_ZERO_BIT];
         nxt_st.nibFlag   = memWdata[sfb_pkg::STAT_NIB_BIT];
         nxt_st.carryFlag = memWdata[sfb_pkg::STAT_CARRY_BIT];
      end
      if (aluValid && aluOp != sfb_pkg::SFB_OP_NONE)
      begin
         nxt_st.aluResult = result;
         nxt_st.zeroFlag  = (result == 8'h00);
         if (isArith)
         begin
            nxt_st.nibFlag   = nibSum[4];
            nxt_st.carryFlag = sum[8];
         end
      end
      // Hardware events; timeout applied last so it overrides a clear or sleep in the same cycle
      if (watchdogClearInstr)
      begin
         nxt_st.wdtFlag   = 1'b1;
         nxt_st.sleepFlag = 1'b1;
      end
      if (sleepInstr)
      begin
         nxt_st.wdtFlag   = 1'b1;
         nxt_st.sleepFlag = 1'b0;
      end
      if (watchdogTimeout)
         nxt_st.wdtFlag = 1'b0;
      // Reads
      if (linRead)
      begin
         nxt_st.rvalid = 1'b1;
         nxt_st.region = 3'(sfb_pkg::SFB_RG_GPR);
         nxt_st.periph = 1'b0;
         nxt_st.rdata  = linHit ? gprMem_ff[linOfs[GPR_IW-1:0]] : 8'h00;
      end
      else if (memRead)
      begin
         nxt_st.rvalid = 1'b1;
         nxt_st.region = 3'(wrRegion);
         nxt_st.periph = (wrRegion == sfb_pkg::SFB_RG_PERIPH);
         case (wrRegion)
            sfb_pkg::SFB_RG_CORE:
               nxt_st.rdata = memIsStatus ? statusByte(st_ff) : 8'h00;
            sfb_pkg::SFB_RG_GPR:
               nxt_st.rdata = ({1'b0, memBank} < 6'(GPR_BANKS))
                              ? gprMem_ff[gprIndex(memBank, memOfs)] : 8'h00;
            sfb_pkg::SFB_RG_COMMON:
               nxt_st.rdata = commonMem_ff[memOfs[3:0]];
            default:
               nxt_st.rdata = 8'h00;
         endcase
      end
      if (!nrst && powerReset)
      begin
         nxt_st = '0;
         nxt_st.wdtFlag   = sfb_pkg::FLAG_RST_POR;
         nxt_st.sleepFlag = sfb_pkg::FLAG_RST_POR;
         nxt_st.region    = 3'(sfb_pkg::SFB_RG_NONE);
      end
      else if (!nrst)
      begin
         // Other resets clear the ALU result but keep result and reset-cause flags; a timeout still clears the watchdog flag
         nxt_st.rvalid    = 1'b0;
         nxt_st.rdata     = 8'h00;
         nxt_st.aluResult = 8'h00;
         nxt_st.periph    = 1'b0;
         nxt_st.region    = 3'(sfb_pkg::SFB_RG_NONE);
         nxt_st.zeroFlag  = st_ff.zeroFlag;
         nxt_st.nibFlag   = st_ff.nibFlag;
         nxt_st.carryFlag = st_ff.carryFlag;
         nxt_st.wdtFlag   = watchdogTimeout ? 1'b0 : st_ff.wdtFlag;
         nxt_st.sleepFlag = st_ff.sleepFlag;
      end
   end

   always_ff @(posedge clock)
   begin
      st_ff <= nxt_st;
      if (nrst && gprWe)
         gprMem_ff[gprWi] <= memWdata;
      if (nrst && comWe)
         commonMem_ff[comWi] <= memWdata;
   end

   assign aluResult = st_ff.aluResult;
   assign statusOut = statusByte(st_ff) & sfb_pkg::STAT_IMPL_MASK;
   assign memRdata  = st_ff.rdata;
   assign memRvalid = st_ff.rvalid;
   assign memRegion = st_ff.region;
   assign periphSel = st_ff.periph;

endmodule // sfb_status_banks

//--- sim/sfb_checker.sv
`timescale 1ns/1ns
module sfb_checker (
   // Clock and reset
   input wire logic             clock,
   input wire logic             nrst,
   // Events and requests
   input wire logic             watchdogClearInstr,
   input wire logic             sleepInstr,
   input wire logic             watchdogTimeout,
   input wire logic             aluValid,
   input wire sfb_pkg::sfb_op_t aluOp,
   input wire logic [7:0]       aluA,
   input wire logic [7:0]       aluB,
   input wire logic             memWrite,
   input wire logic [11:0]      memAddr,
   input wire logic [7:0]       memWdata,
   // Results
   input wire logic [7:0]       aluResult,
   input wire logic [7:0]       statusOut
);
   logic isAdd;
   logic isSub;
   logic statWr;
   assign isAdd = aluValid && aluOp == sfb_pkg::SFB_OP_ADD;
   assign isSub = aluValid && aluOp == sfb_pkg::SFB_OP_SUB;
   // Only a quiet cycle shows the plain write path
   assign statWr = memWrite && memAddr[6:0] == 7'h03 && !aluValid
      && !watchdogClearInstr && !sleepInstr && !watchdogTimeout;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   a_top_zero: assert property (statusOut[7:5] == 3'h0)
      else $error("upper status bits set");
   a_timeout_clr: assert property (watchdogTimeout |=> !statusOut[4])
      else $error("timeout left expiry flag");
   a_sleep_flags: assert property (sleepInstr && !watchdogTimeout |=> statusOut[4:3] == 2'b10)
      else $error("sleep flags wrong");
   a_add_carry: assert property (isAdd |=> {statusOut[0], aluResult} == {1'b0, $past(aluA)} + {1'b0, $past(aluB)})
      else $error("add sum or carry wrong");
   a_sub_borrow: assert property (isSub |=> {statusOut[0], aluResult} == {1'b0, $past(aluA)} + {1'b0, ~$past(aluB)} + 9'h001)
      else $error("sub result or borrow wrong");
   a_nib_add: assert property (isAdd |=> statusOut[1] == ({1'b0, $past(aluA[3:0])} + {1'b0, $past(aluB[3:0])} > 5'h0f))
      else $error("nibble carry wrong");
   a_zero_flag: assert property (isAdd || isSub |=> statusOut[2] == (aluResult == 8'h00))
      else $error("zero flag wrong");
   a_ro_write: assert property (statWr |=> statusOut[4:0] == {$past(statusOut[4:3]), $past(memWdata[2:0])})
      else $error("status write access wrong");
endmodule // sfb_checker

bind sfb_status_banks sfb_checker u_chk (.clock(clock), .nrst(nrst),
   .watchdogClearInstr(watchdogClearInstr), .sleepInstr(sleepInstr),
   .watchdogTimeout(watchdogTimeout), .aluValid(aluValid), .aluOp(aluOp), .aluA(aluA),
   .aluB(aluB), .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata),
   .aluResult(aluResult), .statusOut(statusOut));

//--- sim/sfb_cpu_model.sv
`timescale 1ns/1ns
module sfb_cpu_model (
   // Clock
   input  wire logic        clock,
   // Completed operation
   output logic             aluValid,
   output sfb_pkg::sfb_op_t aluOp,
   output logic [7:0]       aluA,
   output logic [7:0]       aluB,
   output logic [11:0]      aluDest,
   output logic             aluToFile
);
   initial
   begin
      {aluValid, aluToFile, aluA, aluB, aluDest} = 30'h0;
      aluOp = sfb_pkg::SFB_OP_NONE;
   end
   // Pulse lasts one edge; operands scrambled afterwards
   task automatic issue(input sfb_pkg::sfb_op_t op, input logic [7:0] a, b, input logic tf);
      @(posedge clock);
      aluValid  <= 1'b1;
      aluOp     <= op;
      aluA      <= a;
      aluB      <= b;
      aluToFile <= tf;
      aluDest   <= tf ? 12'h003 : 12'h020;
      @(posedge clock);
      aluValid  <= 1'b0;
      aluA      <= ~a;
      aluB      <= ~b;
   endtask
endmodule // sfb_cpu_model

//--- sim/tb.sv
`timescale 1ns/1ns
module tb;
   logic clock, nrst, powerReset, watchdogClearInstr, sleepInstr, watchdogTimeout;
   logic memWrite, memRead, linRead, linWrite, memRvalid, periphSel, aluValid, aluToFile;
   logic [11:0] memAddr, aluDest;
   logic [15:0] linAddr, la;
   logic [7:0] memWdata, aluA, aluB, aluResult, statusOut, memRdata, ra, rb;
   logic [2:0] memRegion, fl;
   logic [1:0] tp;
   logic [10:0] e;
   sfb_pkg::sfb_op_t aluOp, op;
   int err_total, comparisons, seed, i, bk, of;
   logic [2:0] ev[4] = '{3'b010, 3'b110, 3'b001, 3'b100};
   logic [1:0] te[4] = '{2'b10, 2'b00, 2'b11, 2'b01};
   logic [7:0] ca[4] = '{8'h0f, 8'h05, 8'h00, 8'hff};
   logic [7:0] cb[4] = '{8'h01, 8'h03, 8'h01, 8'h01};

   sfb_status_banks #(.GPR_BANKS(8)) u_sfb_status_banks (.clock(clock), .nrst(nrst),
      .powerReset(powerReset), .watchdogClearInstr(watchdogClearInstr),
      .sleepInstr(sleepInstr), .watchdogTimeout(watchdogTimeout), .aluValid(aluValid),
      .aluOp(aluOp), .aluA(aluA), .aluB(aluB), .aluDest(aluDest), .aluToFile(aluToFile),
      .memWrite(memWrite), .memRead(memRead), .memAddr(memAddr), .memWdata(memWdata),
      .linRead(linRead), .linWrite(linWrite), .linAddr(linAddr), .aluResult(aluResult),
      .statusOut(statusOut), .memRdata(memRdata), .memRvalid(memRvalid),
      .memRegion(memRegion), .periphSel(periphSel));
   sfb_cpu_model u_cpu (.clock(clock), .aluValid(aluValid), .aluOp(aluOp), .aluA(aluA),
      .aluB(aluB), .aluDest(aluDest), .aluToFile(aluToFile));

   function automatic logic [10:0] alu_exp(sfb_pkg::sfb_op_t o, logic [7:0] a, b, logic [2:0] f);
      logic [8:0] s;
      logic [4:0] n;
      logic [7:0] bb;
      logic       sb;
      sb = o == sfb_pkg::SFB_OP_SUB;
      bb = sb ? ~b : b;
      s = {1'b0, a} + {1'b0, bb} + {8'h00, sb};
      n = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sb};
      if (o == sfb_pkg::SFB_OP_LOGIC)
         return {a & b, (a & b) == 8'h00, f[1:0]};
      return {s[7:0], s[7:0] == 8'h00, n[4], s[8]};
   endfunction

   task automatic chk(input logic [7:0] g, x);
      comparisons++;
      if (g !== x)
      begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, g, x);
      end
   endtask

   task automatic acc(input logic w, l, input logic [15:0] ad, input logic [7:0] d);
      @(posedge clock);
      {memWrite, memRead, linWrite, linRead} <= {w & !l, !w & !l, w & l, !w & l};
      memAddr  <= ad[11:0];
      linAddr  <= ad;
      memWdata <= d;
      @(posedge clock);
      {memWrite, memRead, linWrite, linRead} <= 4'h0;
      memWdata <= ~d;
      #1;
      if (!w)
      begin
         chk(memRdata, d);
         chk({7'h0, memRvalid}, 8'h01);
      end
   endtask

   task end_sim;
      $display("Comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   initial
   begin
      #400000;
      err_total++;
      end_sim;
   end

   initial
   begin
      seed = 32'h102a41bf;
      {nrst, watchdogClearInstr, sleepInstr, watchdogTimeout, memWrite, memRead} = 6'h0;
      {linRead, linWrite, memAddr, linAddr, memWdata} = 38'h0;
      powerReset = 1'b1;
      repeat (5) @(posedge clock);
      nrst <= 1'b1;
      powerReset <= 1'b0;
      #1;
      chk(statusOut, 8'h18);
      {tp, fl} = 5'h18;
      for (i = 0; i < 24; i++)
      begin
         op = sfb_pkg::sfb_op_t'(3'($unsigned($random(seed)) % 3 + 1));
         ra = i < 4 ? ca[i] : 8'($random(seed));
         rb = i < 4 ? cb[i] : 8'($random(seed));
         op = i < 4 ? (i % 3 == 0 ? sfb_pkg::SFB_OP_ADD : sfb_pkg::SFB_OP_SUB) : op;
         u_cpu.issue(op, ra, rb, 1'b0);
         #1;
         e = alu_exp(op, ra, rb, fl);
         fl = e[2:0];
         chk(aluResult, e[10:3]);
         chk(statusOut, {3'h0, tp, fl});
      end
      acc(1'b1, 1'b0, 16'h0283, 8'hff);
      fl = 3'h7;
      chk(statusOut, {3'h0, tp, fl});
      fork
         u_cpu.issue(sfb_pkg::SFB_OP_ADD, 8'h00, 8'h00, 1'b1);
         acc(1'b1, 1'b0, 16'h0003, 8'h07);
      join
      fl = 3'h4;
      chk(statusOut, {3'h0, tp, fl});
      acc(1'b0, 1'b0, 16'h0f83, {3'h0, tp, fl});
      chk({5'h0, memRegion}, {5'h0, sfb_pkg::SFB_RG_CORE});
      for (i = 0; i < 4; i++)
      begin
         @(posedge clock);
         {watchdogTimeout, sleepInstr, watchdogClearInstr} <= ev[i];
         @(posedge clock);
         {watchdogTimeout, sleepInstr, watchdogClearInstr} <= 3'h0;
         #1;
         tp = te[i];
         chk(statusOut, {3'h0, tp, fl});
      end
      @(posedge clock);
      nrst <= 1'b0;
      @(posedge clock);
      nrst <= 1'b1;
      #1;
      chk(statusOut, {3'h0, tp, fl});
      acc(1'b1, 1'b0, 16'h00f5, 8'ha5);
      acc(1'b0, 1'b0, 16'h0375, 8'ha5);
      chk({5'h0, memRegion}, {5'h0, sfb_pkg::SFB_RG_COMMON});
      acc(1'b0, 1'b0, 16'h010c, 8'h00);
      chk({4'h0, periphSel, memRegion}, {4'h0, 1'b1, sfb_pkg::SFB_RG_PERIPH});
      acc(1'b1, 1'b0, 16'h04a0, 8'h77);
      acc(1'b0, 1'b0, 16'h04a0, 8'h00);
      acc(1'b1, 1'b1, 16'h222f, 8'h5a);
      acc(1'b0, 1'b0, 16'h036f, 8'h5a);
      acc(1'b0, 1'b1, 16'h2280, 8'h00);
      for (i = 0; i < 6; i++)
      begin
         bk = $unsigned($random(seed)) % 8;
         of = 32 + $unsigned($random(seed)) % 80;
         ra = 8'($random(seed));
         la = 16'h2000 + 16'(bk * 80 + of - 32);
         acc(1'b1, 1'b0, {4'h0, 5'(bk), 7'(of)}, ra);
         acc(1'b0, 1'b1, la, ra);
         acc(1'b0, 1'b0, {4'h0, 5'(bk), 7'(of)}, ra);
         chk({5'h0, memRegion}, {5'h0, sfb_pkg::SFB_RG_GPR});
      end
      end_sim;
   end
endmodule // tb
